// *** core/det_if.sv ***
// Filtered level and falling-edge pulse from one pin detector
`timescale 1ns/1ps
`default_nettype none
interface det_if;
   logic low;
   logic fell;
   modport src (output low, output fell);
   modport dst (input low, input fell);
endinterface : det_if
`default_nettype wire

// *** core/irq_front.sv ***
// External request flags, enables and sense select behind an AXI4-Lite slave
// Notes on behaviour
// - Level mode: flag sets while the request pin is low.
// - Edge mode: flag sets on a high-to-low pin transition.
// - Writing 0 clears a flag only after it was read as 1.
// - Level mode: exception handling with pin high clears the flag.
// - Edge mode: exception handling clears the flag.
// - Software writes can only clear flags, never set them.
// - Flag register is 8 bits, zero after reset and in standby.
// - Flag bits 7,6,3,2 ignore writes and read zero.
// - Enable bits 5,4,1,0 gate their own line; 1 enables.
// - Enable register is zero after reset and in standby.
// - Enable bits 7,6,3,2 ignore writes and read zero.
// - Sense bit 0 selects low level, 1 selects falling edge.
// - Sense bits 7,6,3,2 are plain storage with no effect.
// - Sense register is zero after reset and in standby.
// - Lines 5,4,1,0 request vectors 17,16,13,12.
// - Detection works whatever the pin direction.
`timescale 1ns/1ps
`default_nettype none
module irq_front
   import irq_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic [3:0]        external_request_pin_n,
   input  wire logic              standby_n,
   input  wire logic [3:0]        exception_ack,
   output logic [3:0]             line_request,
   output logic [7:0]             request_vector,
   output logic                   request_pending,
   output logic                   irq
);
   logic [3:0]        low_v;
   logic [3:0]        fell_v;
   logic              stby_low;
   logic              standby;
   logic [3:0]        flags_ff;
   logic [3:0]        seen_ff;
   logic [3:0]        en_ff;
   logic [7:0]        sense_ff;
   logic [3:0]        evt_ff;
   logic [3:0]        mask_ff;
   logic              awready_ff;
   logic              wready_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic [ADDR_W-1:0] waddr_ff;
   logic [31:0]       wdata_ff;
   logic              wlane0_ff;
   logic              arready_ff;
   logic              rvalid_ff;
   logic [31:0]       rdata_ff;
   logic [1:0]        rresp_ff;
   logic [3:0]        line_req_ff;
   logic [7:0]        vector_ff;
   logic              pending_ff;
   logic              irq_ff;
   logic [3:0]        sense4;
   logic [3:0]        lvl_set_v;
   logic [3:0]        edge_set_v;
   logic [3:0]        set_v;
   logic [3:0]        ack_clr_v;
   logic [3:0]        sw_clr_v;
   logic [3:0]        nxt_flags;
   logic [3:0]        nxt_seen;
   logic [3:0]        nxt_evt;
   logic [3:0]        req_v;
   logic [3:0]        wr_bits;
   logic              do_wr;
   logic              wr_flags;
   logic              rd_hs;
   logic              rd_flags;
   logic              rd_evt;
   logic [31:0]       rd_word;
   logic              rd_err;
   logic              wr_err;

   // Pin path is sampled directly, so output-mode pins still detect
   for (genvar i = 0; i < NLINES; i++) begin : g_line
      det_if d ();
      pin_detect u_det (
         .aclk    (aclk),
         .aresetn (aresetn),
         .pin_in  (external_request_pin_n[i]),
         .det     (d.src)
      );
      assign low_v[i]  = d.low;
      assign fell_v[i] = d.fell;
   end

   det_if ds ();
   pin_detect u_stby (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (standby_n),
      .det     (ds.src)
   );
   assign stby_low = ds.low;
   assign standby  = stby_low;

   // Detection and clearing conditions
   assign sense4     = unpack_lines(sense_ff);
   assign lvl_set_v  = ~sense4 & low_v;
   assign edge_set_v = sense4 & fell_v;
   assign set_v      = lvl_set_v | edge_set_v;
   assign ack_clr_v  = exception_ack & (sense4 | ~low_v);
   assign wr_bits    = unpack_lines(wdata_ff[7:0]);
   assign sw_clr_v   = wr_flags ? (~wr_bits & seen_ff) : 4'h0;
   // Set wins over an acknowledge or write clear in the same cycle
   assign nxt_flags  = (flags_ff & ~(ack_clr_v | sw_clr_v)) | set_v;
   assign nxt_seen   = wr_flags ? 4'h0
                     : (seen_ff | (rd_flags ? flags_ff : 4'h0)) & nxt_flags;
   assign nxt_evt    = (rd_evt ? 4'h0 : evt_ff) | (set_v & ~flags_ff);
   assign req_v      = flags_ff & en_ff;

   // Write channel: address and data captured in either order
   assign do_wr    = ~awready_ff & ~wready_ff & ~bvalid_ff;
   assign wr_flags = do_wr & wlane0_ff & (waddr_ff == OFS_FLAGS);
   assign rd_hs    = arvalid & arready_ff;
   assign rd_flags = rd_hs & (araddr == OFS_FLAGS);
   assign rd_evt   = rd_hs & (araddr == OFS_EVT);

   // Event status is read-only: a write there is answered but changes nothing
   always_comb begin
      wr_err = 1'b1;
      if (waddr_ff == OFS_FLAGS || waddr_ff == OFS_EN || waddr_ff == OFS_SENSE) begin
         wr_err = 1'b0;
      end else if (waddr_ff == OFS_EVT || waddr_ff == OFS_MASK) begin
         wr_err = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         waddr_ff   <= '0;
         wdata_ff   <= '0;
         wlane0_ff  <= 1'b0;
      end else begin
         if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            waddr_ff   <= awaddr;
         end
         if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff  <= wdata;
            wlane0_ff <= wstrb[0];
         end
         if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_ff && bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // Read decode; reserved bits come back as zero
   always_comb begin
      rd_word = 32'h0;
      rd_err  = 1'b0;
      if (araddr == OFS_FLAGS) begin
         rd_word[7:0] = pack_lines(flags_ff);
      end else if (araddr == OFS_EN) begin
         rd_word[7:0] = pack_lines(en_ff);
      end else if (araddr == OFS_SENSE) begin
         rd_word[7:0] = sense_ff;
      end else if (araddr == OFS_EVT) begin
         rd_word[7:0] = pack_lines(evt_ff);
      end else if (araddr == OFS_MASK) begin
         rd_word[7:0] = pack_lines(mask_ff);
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= RESP_OKAY;
      end else if (rd_hs) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_word;
         rresp_ff   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_ff && rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // Request flags; standby wipes them like reset
   always_ff @(posedge aclk) begin
      if (!aresetn || standby) begin
         flags_ff <= unpack_lines(RST_FLAGS);
         seen_ff  <= 4'h0;
      end else begin
         flags_ff <= nxt_flags;
         seen_ff  <= nxt_seen;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || standby) begin
         en_ff <= unpack_lines(RST_EN);
      end else if (do_wr && wlane0_ff && waddr_ff == OFS_EN) begin
         en_ff <= wr_bits;
      end
   end

   // All eight sense bits are kept, only four steer detection
   always_ff @(posedge aclk) begin
      if (!aresetn || standby) begin
         sense_ff <= RST_SENSE;
      end else if (do_wr && wlane0_ff && waddr_ff == OFS_SENSE) begin
         sense_ff <= wdata_ff[7:0];
      end
   end

   // Event status is cleared by reading it; a new event wins
   always_ff @(posedge aclk) begin
      if (!aresetn || standby) begin
         evt_ff <= RST_EVT;
      end else begin
         evt_ff <= nxt_evt;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_ff <= RST_MASK;
      end else if (do_wr && wlane0_ff && waddr_ff == OFS_MASK) begin
         mask_ff <= wr_bits;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(evt_ff & mask_ff);
      end
   end

   // Smaller vector wins, matching the default priority order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_req_ff <= 4'h0;
         vector_ff   <= VEC_NONE;
         pending_ff  <= 1'b0;
      end else begin
         line_req_ff <= req_v;
         pending_ff  <= |req_v;
         if (req_v[0]) begin
            vector_ff <= VEC_LINE0;
         end else if (req_v[1]) begin
            vector_ff <= VEC_LINE1;
         end else if (req_v[2]) begin
            vector_ff <= VEC_LINE4;
         end else if (req_v[3]) begin
            vector_ff <= VEC_LINE5;
         end else begin
            vector_ff <= VEC_NONE;
         end
      end
   end

   assign awready         = awready_ff;
   assign wready          = wready_ff;
   assign bvalid          = bvalid_ff;
   assign bresp           = bresp_ff;
   assign arready         = arready_ff;
   assign rvalid          = rvalid_ff;
   assign rdata           = rdata_ff;
   assign rresp           = rresp_ff;
   assign line_request    = line_req_ff;
   assign request_vector  = vector_ff;
   assign request_pending = pending_ff;
   assign irq             = irq_ff;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_flag_write;
      do_wr && wlane0_ff && waddr_ff == OFS_FLAGS;
   endsequence

   sequence s_flag_read;
      rd_flags;
   endsequence

   AST_LEVEL_SET: assert property (
      (lvl_set_v != 4'h0) && !standby |=> (flags_ff & $past(lvl_set_v)) == $past(lvl_set_v))
      else $error("level request did not set its flag");

   AST_EDGE_SET: assert property (
      (edge_set_v != 4'h0) && !standby |=> (flags_ff & $past(edge_set_v)) == $past(edge_set_v))
      else $error("falling edge did not set its flag");

   AST_CLEAR_NEEDS_READ: assert property (
      s_flag_write ##0 (seen_ff == 4'h0) && exception_ack == 4'h0 && !standby
      |=> (~flags_ff & $past(flags_ff)) == 4'h0)
      else $error("flag cleared without prior read");

   AST_READ_THEN_CLEAR: assert property (
      s_flag_read ##[1:8] (s_flag_write ##0 (!standby && seen_ff != 4'h0
      && wr_bits == 4'h0 && set_v == 4'h0)) |=> (flags_ff & $past(seen_ff)) == 4'h0)
      else $error("read-then-write 0 did not clear flag");

   AST_LEVEL_ACK: assert property (
      (exception_ack & ~sense4 & ~low_v & ~set_v) != 4'h0
      |=> (flags_ff & $past(exception_ack) & ~$past(sense4) & ~$past(low_v)) == 4'h0)
      else $error("level flag kept after handling with pin high");

   AST_EDGE_ACK: assert property (
      (exception_ack & sense4 & ~set_v) != 4'h0
      |=> (flags_ff & $past(exception_ack) & $past(sense4) & ~$past(set_v)) == 4'h0)
      else $error("edge flag kept after handling");

   AST_NO_SW_SET: assert property (
      (flags_ff & ~$past(flags_ff)) != 4'h0
      |-> (flags_ff & ~$past(flags_ff) & ~$past(set_v)) == 4'h0)
      else $error("flag set without a detected request");

   AST_STANDBY_CLEAR: assert property (
      standby |=> flags_ff == 4'h0 && en_ff == 4'h0 && sense_ff == RST_SENSE)
      else $error("standby left a register non-zero");

   AST_RESERVED_ZERO: assert property (
      rvalid_ff && rresp_ff == RESP_OKAY |-> (rdata_ff[31:8] == 24'h0))
      else $error("reserved read bits not zero");

   AST_GATE: assert property (
      line_req_ff != 4'h0 |-> ($past(en_ff) & line_req_ff) == line_req_ff)
      else $error("request presented for a disabled line");

   AST_VECTOR: assert property (
      req_v[0] |=> vector_ff == VEC_LINE0 && pending_ff ##1 1'b1)
      else $error("line 0 vector wrong");
endmodule : irq_front
`default_nettype wire

// *** core/irq_pkg.sv ***
// Constants and helpers shared by the external request front end
package irq_pkg;
   localparam int          ADDR_W     = 8;
   localparam int          NLINES     = 4;
   localparam logic [7:0]  OFS_FLAGS  = 8'h00;
   localparam logic [7:0]  OFS_EN     = 8'h04;
   localparam logic [7:0]  OFS_SENSE  = 8'h08;
   localparam logic [7:0]  OFS_EVT    = 8'h0C;
   localparam logic [7:0]  OFS_MASK   = 8'h10;
   localparam logic [7:0]  RST_FLAGS  = 8'h00;
   localparam logic [7:0]  RST_EN     = 8'h00;
   localparam logic [7:0]  RST_SENSE  = 8'h00;
   localparam logic [3:0]  RST_EVT    = 4'h0;
   localparam logic [3:0]  RST_MASK   = 4'h0;
   localparam logic [7:0]  VEC_LINE0  = 8'h0C;
   localparam logic [7:0]  VEC_LINE1  = 8'h0D;
   localparam logic [7:0]  VEC_LINE4  = 8'h10;
   localparam logic [7:0]  VEC_LINE5  = 8'h11;
   localparam logic [7:0]  VEC_NONE   = 8'h00;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic        PIN_IDLE   = 1'b1;

   // Line index 3..0 stands for lines 5, 4, 1, 0 at register bits 5, 4, 1, 0
   function automatic logic [7:0] pack_lines(input logic [3:0] v);
      pack_lines = {2'h0, v[3], v[2], 2'h0, v[1], v[0]};
   endfunction : pack_lines

   function automatic logic [3:0] unpack_lines(input logic [7:0] r);
      unpack_lines = {r[5], r[4], r[1], r[0]};
   endfunction : unpack_lines
endpackage : irq_pkg

// *** core/pin_detect.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_detect
   import irq_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin_in,
   det_if.src        det
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic filt_ff;
   logic fell_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= PIN_IDLE;
         s2_ff <= PIN_IDLE;
         s3_ff <= PIN_IDLE;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A change counts only once the second and third stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_ff <= PIN_IDLE;
         fell_ff <= 1'b0;
      end else begin
         fell_ff <= 1'b0;
         if (s2_ff == s3_ff) begin
            filt_ff <= s3_ff;
            fell_ff <= filt_ff & ~s3_ff;
         end
      end
   end

   assign det.low  = ~filt_ff;
   assign det.fell = fell_ff;
endmodule : pin_detect
`default_nettype wire

// *** tb/external_irq_flag_enable_sense_tb.sv ***
// Self-checking bench for the external request front end
`timescale 1ns/1ps
`default_nettype none
module external_irq_flag_enable_sense_tb;
   import irq_pkg::*;
   localparam int LIMIT = 20000;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, standby_n, request_pending, irq;
   logic [7:0]  awaddr, araddr, request_vector;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, pins_n, exception_ack, line_request, hold_low, pulse_go;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rd;
   logic [7:0]  vec_tab [4];
   logic [7:0]  bit_tab [4];
   int          miscompares, cmp_count, cycles;

   irq_front DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .external_request_pin_n(pins_n), .standby_n(standby_n), .exception_ack(exception_ack),
      .line_request(line_request), .request_vector(request_vector),
      .request_pending(request_pending), .irq(irq));
   pin_driver #(.PULSE_LEN(6)) pins (.aclk(aclk), .aresetn(aresetn), .hold_low(hold_low),
      .pulse_go(pulse_go), .pins_n(pins_n));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic close_out();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   initial begin
      cycles = 0;
      forever begin
         @(posedge aclk);
         cycles++;
         if (cycles >= LIMIT) begin
            miscompares++;
            close_out();
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      bit aw_done;
      bit w_done;
      aw_done = 0;
      w_done  = 0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready) begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rdx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rdx

   task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
      wr(a, d, rsp);
      chk("write response", {30'h0, RESP_OKAY}, {30'h0, rsp});
   endtask : wr_ok

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      rdx(a, rd, rsp);
      chk(what, {24'h0, exp}, rd);
   endtask : rd_chk

   task automatic ack(input int i);
      @(posedge aclk);
      exception_ack[i] <= 1'b1;
      @(posedge aclk);
      exception_ack[i] <= 1'b0;
   endtask : ack

   // Bounded wait for a line to reach the request logic
   task automatic wait_req(input int i);
      int n;
      n = 0;
      while (line_request[i] !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk("line request raised", 32'h1, {31'h0, line_request[i]});
   endtask : wait_req

   task automatic t_reset();
      rd_chk("flags at reset", OFS_FLAGS, RST_FLAGS);
      rd_chk("enables at reset", OFS_EN, RST_EN);
      rd_chk("sense at reset", OFS_SENSE, RST_SENSE);
      chk("request vector idle", {24'h0, VEC_NONE}, {24'h0, request_vector});
      chk("irq idle", 32'h0, {31'h0, irq});
   endtask : t_reset

   task automatic t_access();
      wstrb <= 4'h0;
      wr_ok(OFS_EN, 8'hFF);
      wstrb <= 4'hF;
      rd_chk("strobe off ignored", OFS_EN, 8'h00);
      wr_ok(OFS_EN, 8'hFF);
      rd_chk("enable reserved bits", OFS_EN, 8'h33);
      wr_ok(OFS_SENSE, 8'hFF);
      rd_chk("sense spare bits", OFS_SENSE, 8'hFF);
      wr_ok(OFS_FLAGS, 8'hFF);
      rd_chk("flags not settable", OFS_FLAGS, 8'h00);
      rdx(8'h14, rd, rsp);
      chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      chk("unmapped read data", 32'h0, rd);
      wr(8'h14, 8'hFF, rsp);
      chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      wr_ok(OFS_EN, 8'h00);
      wr_ok(OFS_SENSE, 8'h00);
   endtask : t_access

   task automatic t_level();
      hold_low <= 4'h2;
      idle(8);
      rd_chk("level flag set", OFS_FLAGS, 8'h02);
      chk("disabled line quiet", 32'h0, {28'h0, line_request});
      wr_ok(OFS_EN, 8'h02);
      wait_req(1);
      chk("vector line1", {24'h0, VEC_LINE1}, {24'h0, request_vector});
      hold_low <= 4'h0;
      idle(8);
      wr_ok(OFS_FLAGS, 8'hFF);
      rd_chk("ones do not clear", OFS_FLAGS, 8'h02);
      wr_ok(OFS_FLAGS, 8'hFF);
      wr_ok(OFS_FLAGS, 8'h00);
      rd_chk("unseen flag kept", OFS_FLAGS, 8'h02);
      wr_ok(OFS_FLAGS, 8'h00);
      rd_chk("seen flag cleared", OFS_FLAGS, 8'h00);
      hold_low <= 4'h2;
      idle(8);
      hold_low <= 4'h0;
      idle(8);
      ack(1);
      idle(2);
      rd_chk("level ack clears", OFS_FLAGS, 8'h00);
      wr_ok(OFS_SENSE, 8'hCC);
      hold_low <= 4'h4;
      idle(8);
      rd_chk("spare bits no effect", OFS_FLAGS, 8'h10);
      hold_low <= 4'h0;
      idle(8);
      ack(2);
      wr_ok(OFS_EN, 8'h00);
   endtask : t_level

   task automatic t_edge();
      wr_ok(OFS_SENSE, 8'h33);
      wr_ok(OFS_EN, 8'h33);
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk);
         pulse_go[i] <= 1'b1;
         @(posedge aclk);
         pulse_go[i] <= 1'b0;
         wait_req(i);
         chk("single line", {24'h0, bit_tab[i]}, {24'h0, pack_lines(line_request)});
         chk("edge vector", {24'h0, vec_tab[i]}, {24'h0, request_vector});
         chk("pending raised", 32'h1, {31'h0, request_pending});
         ack(i);
         idle(3);
         chk("edge ack clears", 32'h0, {28'h0, line_request});
         chk("pending cleared", 32'h0, {31'h0, request_pending});
      end
      hold_low <= 4'h1;
      wait_req(0);
      ack(0);
      idle(8);
      chk("held low no re-set", 32'h0, {28'h0, line_request});
      hold_low <= 4'h0;
      idle(4);
   endtask : t_edge

   task automatic t_irq();
      wr_ok(OFS_MASK, 8'h01);
      rdx(OFS_EVT, rd, rsp);
      @(posedge aclk);
      pulse_go <= 4'h2;
      @(posedge aclk);
      pulse_go <= 4'h0;
      wait_req(1);
      idle(2);
      chk("masked event quiet", 32'h0, {31'h0, irq});
      rd_chk("event status", OFS_EVT, 8'h02);
      @(posedge aclk);
      pulse_go <= 4'h1;
      @(posedge aclk);
      pulse_go <= 4'h0;
      wait_req(0);
      idle(2);
      chk("unmasked event irq", 32'h1, {31'h0, irq});
      rd_chk("event status line0", OFS_EVT, 8'h01);
      idle(2);
      chk("read clears irq", 32'h0, {31'h0, irq});
   endtask : t_irq

   task automatic t_standby();
      @(posedge aclk);
      standby_n <= 1'b0;
      idle(4);
      standby_n <= 1'b1;
      idle(4);
      rd_chk("flags after standby", OFS_FLAGS, 8'h00);
      rd_chk("enables after standby", OFS_EN, 8'h00);
      rd_chk("sense after standby", OFS_SENSE, 8'h00);
      chk("no request after standby", 32'h0, {28'h0, line_request});
   endtask : t_standby

   initial begin
      miscompares = 0;
      cmp_count = 0;
      vec_tab = '{VEC_LINE0, VEC_LINE1, VEC_LINE4, VEC_LINE5};
      bit_tab = '{8'h01, 8'h02, 8'h10, 8'h20};
      aresetn = 1'b0;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hF;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      standby_n = 1'b1;
      exception_ack = 4'h0;
      hold_low = 4'h0;
      pulse_go = 4'h0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_access();
      t_level();
      t_edge();
      t_irq();
      t_standby();
      close_out();
   end
endmodule : external_irq_flag_enable_sense_tb
`default_nettype wire

// *** tb/pin_driver.sv ***
// Model of the external circuits that pull the active-low request pins
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(
   parameter int PULSE_LEN = 6
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [3:0] hold_low,
   input  wire logic [3:0] pulse_go,
   output logic      [3:0] pins_n
);
   logic [3:0] pulse_ff;
   int         cnt_ff [4];

   // A pulse must outlast the input filter, otherwise the edge is swallowed
   always_ff @(posedge aclk) begin
      for (int i = 0; i < 4; i++) begin
         if (!aresetn) begin
            pulse_ff[i] <= 1'b0;
            cnt_ff[i]   <= 0;
         end else if (pulse_go[i]) begin
            pulse_ff[i] <= 1'b1;
            cnt_ff[i]   <= PULSE_LEN;
         end else if (cnt_ff[i] > 1) begin
            cnt_ff[i]   <= cnt_ff[i] - 1;
         end else begin
            pulse_ff[i] <= 1'b0;
            cnt_ff[i]   <= 0;
         end
      end
   end

   // Released lines float back high through their pull-ups
   assign pins_n = ~(hold_low | pulse_ff);
endmodule : pin_driver
`default_nettype wire
